//--- gpp_regs.svh
// Purpose: Register indices, field positions and reset values of the port.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// Register indices; the printed offsets are not word aligned.
`define GPP_IDX_LATCH   12'h009
`define GPP_IDX_LEVEL   12'h016
`define GPP_IDX_DIR     12'hf23
`define GPP_IDX_PULL    12'hf30
`define GPP_IDX_FSEL    12'hf3d
`define GPP_IDX_DRIVE   12'hf4a

// Index field of the byte address.
`define GPP_IDX_LSB     2
`define GPP_IDX_MSB     13

// Bit positions of the two pins in every register.
`define GPP_BIT_PIN0    0
`define GPP_BIT_PIN1    1

// Reset values of the writable registers.
`define GPP_RST_LATCH   8'h00
`define GPP_RST_DIR     8'h00
`define GPP_RST_PULL    8'h00
`define GPP_RST_FSEL    8'h00
`define GPP_RST_DRIVE   8'h00

`endif

//--- gpp_pkg.sv
// Purpose: Types shared by the port modules.
// Assumes: Nothing.
// Notes:   Constants live in gpp_regs.svh.
`default_nettype none
package gpp_pkg;

  typedef enum {
    GPP_REG_LATCH,
    GPP_REG_LEVEL,
    GPP_REG_DIR,
    GPP_REG_PULL,
    GPP_REG_FSEL,
    GPP_REG_DRIVE,
    GPP_REG_NONE
  } gpp_reg_t;

endpackage
`default_nettype wire

//--- gpp_pin_if.sv
// Purpose: Carries pin configuration to the driver and pin state back.
// Assumes: One bit per pin in every vector.
// Notes:   Used only between the top and its pin driver.
`timescale 1ns/1ps
`default_nettype none
interface gpp_pin_if #(
  parameter int NPINS = 2
);
  logic [NPINS-1:0] dir;
  logic [NPINS-1:0] latch;
  logic [NPINS-1:0] fsel;
  logic [NPINS-1:0] odrain;
  logic [NPINS-1:0] pullen;
  logic             tx;
  logic [NPINS-1:0] pin_in;
  logic [NPINS-1:0] pin_out;
  logic [NPINS-1:0] pin_oe;
  logic [NPINS-1:0] pull_on;
  logic [NPINS-1:0] rx;

  modport cfg (output dir, latch, fsel, odrain, pullen, tx, pin_in,
               input pin_out, pin_oe, pull_on, rx);
  modport drv (input dir, latch, fsel, odrain, pullen, tx, pin_in,
               output pin_out, pin_oe, pull_on, rx);
endinterface
`default_nettype wire

//--- gpp_pin_drv.sv
// Purpose: Registered output stage, pull-up switch and receive path per pin.
// Assumes: Pin levels are synchronous to pclk.
// Notes:   All outputs are flip-flops, one cycle behind the configuration.
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_drv #(
  parameter int NPINS = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  gpp_pin_if.drv    p
);

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      logic value;

      // Port latch or the transmit line, chosen per pin.
      assign value = p.fsel[i] ? p.tx : p.latch[i]; // RL4

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          p.pin_out[i] <= 1'b0;
          p.pin_oe[i]  <= 1'b0;
        end else if (!p.dir[i]) begin
          p.pin_out[i] <= 1'b0; // RL2
          p.pin_oe[i]  <= 1'b0; // RL2
        end else if (p.odrain[i]) begin
          // A one releases the pin; only a zero is sunk.
          p.pin_out[i] <= 1'b0; // RL5
          p.pin_oe[i]  <= ~value; // RL10
        end else begin
          p.pin_out[i] <= value; // RL3
          p.pin_oe[i]  <= 1'b1; // RL5
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          p.pull_on[i] <= 1'b0;
        end else begin
          p.pull_on[i] <= p.pullen[i] & (~p.dir[i] | p.odrain[i]); // RL7
        end
      end

      // The receiver sees the pin only while it is an input.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          p.rx[i] <= 1'b1;
        end else begin
          p.rx[i] <= p.dir[i] ? 1'b1 : p.pin_in[i]; // RL2
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- gpp_port.sv
// Purpose: Two-pin port with UART alternate function behind an APB slave.
// Assumes: Pin levels and transmit line are synchronous to pclk.
// Notes:   No wait state: pready rises in the first access cycle.
// Summary of operation
// [RL1] Two pins, direction chosen independently.
// [RL2] Direction 0 input (feeds receiver), 1 output.
// [RL3] Port output drives latch value on pin.
// [RL4] Function select 1 lets transmit drive pin.
// [RL5] Drive type 0 push-pull, 1 open-drain.
// [RL6] Per-pin pull-up enable, reset disconnected.
// [RL7] Pull-up only in input or open-drain.
// [RL8] Level read: pin unless push-pull output.
// [RL9] Software also sets external serial routing.
// [RL10] Open-drain one releases the pin.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.svh"
module gpp_port #(
  parameter int NPINS = 2
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [NPINS-1:0]  pin_in,
  output var  logic [NPINS-1:0]  pin_out,
  output var  logic [NPINS-1:0]  pin_oe,
  output var  logic [NPINS-1:0]  pullup_on,
  input  wire logic              uart_transmit_output,
  output var  logic [NPINS-1:0]  uart_receive_input
);

  if (NPINS < 1 || NPINS > 8) begin : g_bad_npins
    $error("NPINS must lie between 1 and 8");
  end

  gpp_pin_if #(.NPINS(NPINS)) p ();

  logic [NPINS-1:0] dir;
  logic [NPINS-1:0] latch;
  logic [NPINS-1:0] fsel;
  logic [NPINS-1:0] odrain;
  logic [NPINS-1:0] pullen;
  logic [NPINS-1:0] level;
  logic             setup;
  logic             wr_en;
  gpp_pkg::gpp_reg_t sel;

  // Shared address decode for the read and write paths.
  function automatic gpp_pkg::gpp_reg_t decode(input logic [15:0] a);
    logic [11:0] idx;
    idx = a[`GPP_IDX_MSB:`GPP_IDX_LSB];
    if (a[15:14] != 2'h0 || a[1:0] != 2'h0) begin
      return gpp_pkg::GPP_REG_NONE;
    end
    case (idx)
      `GPP_IDX_LATCH: return gpp_pkg::GPP_REG_LATCH;
      `GPP_IDX_LEVEL: return gpp_pkg::GPP_REG_LEVEL;
      `GPP_IDX_DIR:   return gpp_pkg::GPP_REG_DIR;
      `GPP_IDX_PULL:  return gpp_pkg::GPP_REG_PULL;
      `GPP_IDX_FSEL:  return gpp_pkg::GPP_REG_FSEL;
      `GPP_IDX_DRIVE: return gpp_pkg::GPP_REG_DRIVE;
      default:        return gpp_pkg::GPP_REG_NONE;
    endcase
  endfunction

  assign sel   = decode(paddr);
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  // A push-pull output reads back as zero, so the latch is not echoed.
  assign level = pin_in & ~(dir & ~odrain); // RL8

  // Answer is prepared in the setup cycle and shown in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && (sel == gpp_pkg::GPP_REG_NONE ||
                 (pwrite && sel == gpp_pkg::GPP_REG_LEVEL));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (sel)
        gpp_pkg::GPP_REG_LATCH: prdata[NPINS-1:0] <= latch;
        gpp_pkg::GPP_REG_LEVEL: prdata[NPINS-1:0] <= level; // RL8
        gpp_pkg::GPP_REG_DIR:   prdata[NPINS-1:0] <= dir;
        gpp_pkg::GPP_REG_PULL:  prdata[NPINS-1:0] <= pullen;
        gpp_pkg::GPP_REG_FSEL:  prdata[NPINS-1:0] <= fsel;
        gpp_pkg::GPP_REG_DRIVE: prdata[NPINS-1:0] <= odrain;
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

  // The direction register is written as a whole; each bit sets the direction of one pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= NPINS'(`GPP_RST_DIR); // RL2
    end else if (wr_en && sel == gpp_pkg::GPP_REG_DIR) begin
      dir <= pwdata[NPINS-1:0]; // RL1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= NPINS'(`GPP_RST_LATCH); // RL3
    end else if (wr_en && sel == gpp_pkg::GPP_REG_LATCH) begin
      latch <= pwdata[NPINS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel <= NPINS'(`GPP_RST_FSEL); // RL4
    end else if (wr_en && sel == gpp_pkg::GPP_REG_FSEL) begin
      fsel <= pwdata[NPINS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odrain <= NPINS'(`GPP_RST_DRIVE); // RL5
    end else if (wr_en && sel == gpp_pkg::GPP_REG_DRIVE) begin
      odrain <= pwdata[NPINS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullen <= NPINS'(`GPP_RST_PULL); // RL6
    end else if (wr_en && sel == gpp_pkg::GPP_REG_PULL) begin
      pullen <= pwdata[NPINS-1:0];
    end
  end

  // The routing of the UART to these pins is set elsewhere; this block
  // only offers the pins. // RL9
  assign p.dir    = dir;
  assign p.latch  = latch;
  assign p.fsel   = fsel;
  assign p.odrain = odrain;
  assign p.pullen = pullen;
  assign p.tx     = uart_transmit_output;
  assign p.pin_in = pin_in;

  gpp_pin_drv #(.NPINS(NPINS)) u_drv (
    .pclk    (pclk),
    .presetn (presetn),
    .p       (p.drv)
  );

  assign pin_out            = p.pin_out;
  assign pin_oe             = p.pin_oe;
  assign pullup_on          = p.pull_on;
  assign uart_receive_input = p.rx;

  // Checks.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  dir_write_a: assert property ( // RL1
    wr_en && sel == gpp_pkg::GPP_REG_DIR |=>
      dir == $past(pwdata[NPINS-1:0]))
    else $error("direction register did not take written value");

  // The receive line leaves reset high, so the reset edge itself is skipped.
  input_idle_a: assert property ( // RL2
    presetn |=> ((pin_oe & ~$past(dir)) == '0) &&
        ((uart_receive_input & ~$past(dir)) == ($past(pin_in) & ~$past(dir))))
    else $error("input pin driven or receive path wrong");

  latch_drive_a: assert property ( // RL3
    ##1 (pin_out & $past(dir & ~fsel & ~odrain)) ==
        ($past(latch) & $past(dir & ~fsel & ~odrain)))
    else $error("push-pull pin does not follow latch");

  tx_drive_a: assert property ( // RL4
    ##1 (pin_out & $past(dir & fsel & ~odrain)) ==
        ({NPINS{$past(uart_transmit_output)}} & $past(dir & fsel & ~odrain)))
    else $error("pin does not follow transmit line");

  drive_type_a: assert property ( // RL5
    ##1 ((pin_out & $past(odrain)) == '0) &&
        ((pin_oe & $past(dir & ~odrain)) == $past(dir & ~odrain)))
    else $error("drive type not honoured");

  pull_reset_a: assert property ( // RL6
    $rose(presetn) |-> pullen == '0 && pullup_on == '0)
    else $error("pull-up not disconnected after reset");

  pull_switch_a: assert property ( // RL7
    ##1 pullup_on == $past(pullen & (~dir | odrain)))
    else $error("pull-up connection wrong");

  level_read_a: assert property ( // RL8
    setup && !pwrite && sel == gpp_pkg::GPP_REG_LEVEL |=>
      prdata == {{(32-NPINS){1'b0}}, $past(pin_in & ~(dir & ~odrain))})
    else $error("input level read wrong");

  od_release_a: assert property ( // RL10
    ##1 (pin_oe & $past(dir & odrain)) ==
        (~$past((fsel & {NPINS{uart_transmit_output}}) | (~fsel & latch))
         & $past(dir & odrain)))
    else $error("open-drain pin not released on one");

  answer_time_a: assert property (
    setup |=> pready ##1 !pready || setup)
    else $error("access phase answer not one cycle");

  // A register takes a write only when it is addressed and the transfer
  // is accepted, so a refused transfer can never disturb the pins.
  latch_write_a: assert property ( // RL3
    wr_en && sel == gpp_pkg::GPP_REG_LATCH |=>
      latch == $past(pwdata[NPINS-1:0]))
    else $error("latch register did not take written value");

  fsel_write_a: assert property ( // RL4
    wr_en && sel == gpp_pkg::GPP_REG_FSEL |=>
      fsel == $past(pwdata[NPINS-1:0]))
    else $error("function select did not take written value");

  drive_write_a: assert property ( // RL5
    wr_en && sel == gpp_pkg::GPP_REG_DRIVE |=>
      odrain == $past(pwdata[NPINS-1:0]))
    else $error("drive type did not take written value");

  pull_write_a: assert property ( // RL6
    wr_en && sel == gpp_pkg::GPP_REG_PULL |=>
      pullen == $past(pwdata[NPINS-1:0]))
    else $error("pull-up control did not take written value");

  // Without an accepted write to it, every writable register keeps its value.
  dir_hold_a: assert property ( // RL1
    !(wr_en && sel == gpp_pkg::GPP_REG_DIR) |=> $stable(dir))
    else $error("direction register changed without a write");

  latch_hold_a: assert property ( // RL3
    !(wr_en && sel == gpp_pkg::GPP_REG_LATCH) |=> $stable(latch))
    else $error("latch register changed without a write");

  fsel_hold_a: assert property ( // RL4
    !(wr_en && sel == gpp_pkg::GPP_REG_FSEL) |=> $stable(fsel))
    else $error("function select changed without a write");

  drive_hold_a: assert property ( // RL5
    !(wr_en && sel == gpp_pkg::GPP_REG_DRIVE) |=> $stable(odrain))
    else $error("drive type changed without a write");

  pull_hold_a: assert property ( // RL6
    !(wr_en && sel == gpp_pkg::GPP_REG_PULL) |=> $stable(pullen))
    else $error("pull-up control changed without a write");

  // Pin side: an input is left alone, an output idles the receiver.
  input_release_a: assert property ( // RL2
    ##1 ((pin_out | pin_oe) & ~$past(dir)) == '0)
    else $error("input pin is driven");

  receive_idle_a: assert property ( // RL2
    ##1 (uart_receive_input & $past(dir)) == $past(dir))
    else $error("receive line not idle on an output pin");

  pp_pull_off_a: assert property ( // RL7
    ##1 (pullup_on & $past(dir & ~odrain)) == '0)
    else $error("pull-up connected on a push-pull output");

  drive_high_a: assert property ( // RL5
    (pin_out & ~pin_oe) == '0)
    else $error("pin shows a high level it does not drive");

  level_mask_a: assert property ( // RL8
    setup && !pwrite && sel == gpp_pkg::GPP_REG_LEVEL |=>
      prdata[31:NPINS] == '0 &&
      (prdata[NPINS-1:0] & $past(dir & ~odrain)) == '0)
    else $error("level read shows a push-pull pin or upper bits");

  // Bus side: refusals change nothing and answers come in one cycle.
  refused_write_a: assert property (
    psel && penable && pready && pwrite && pslverr |=>
      $stable(dir) && $stable(latch) && $stable(fsel) &&
      $stable(odrain) && $stable(pullen))
    else $error("refused write changed a register");

  error_ready_a: assert property (
    pslverr |-> pready)
    else $error("error shown outside the access cycle");

  read_upper_a: assert property (
    pready && !pwrite |-> prdata[31:NPINS] == '0)
    else $error("read data upper bits not zero");

  ready_idle_a: assert property (
    !setup |=> !pready)
    else $error("ready raised without a setup cycle");

  // Register read-back returns the stored bits in the low positions.
  dir_read_a: assert property ( // RL1
    setup && !pwrite && sel == gpp_pkg::GPP_REG_DIR |=>
      prdata[NPINS-1:0] == $past(dir))
    else $error("direction read-back wrong");

  latch_read_a: assert property ( // RL3
    setup && !pwrite && sel == gpp_pkg::GPP_REG_LATCH |=>
      prdata[NPINS-1:0] == $past(latch))
    else $error("latch read-back wrong");

  fsel_read_a: assert property ( // RL4
    setup && !pwrite && sel == gpp_pkg::GPP_REG_FSEL |=>
      prdata[NPINS-1:0] == $past(fsel))
    else $error("function select read-back wrong");

  drive_read_a: assert property ( // RL5
    setup && !pwrite && sel == gpp_pkg::GPP_REG_DRIVE |=>
      prdata[NPINS-1:0] == $past(odrain))
    else $error("drive type read-back wrong");

  pull_read_a: assert property ( // RL6
    setup && !pwrite && sel == gpp_pkg::GPP_REG_PULL |=>
      prdata[NPINS-1:0] == $past(pullen))
    else $error("pull-up control read-back wrong");

endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the two-pin port behind its APB slave.
// Assumes: Register byte address is four times its index.
// Notes:   Pin outputs are checked two edges after the write completes.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.svh"
`define TB_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [15:0] paddr   = 16'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pin_in  = 2'h0;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  logic [1:0]  pullup_on;
  logic        tx      = 1'b0;
  logic [1:0]  rx;
  int          err_total    = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  logic [11:0] rw_idx [5] = '{`GPP_IDX_LATCH, `GPP_IDX_DIR, `GPP_IDX_PULL,
                              `GPP_IDX_FSEL, `GPP_IDX_DRIVE};

  gpp_port #(.NPINS(2)) gpp_port_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .uart_transmit_output(tx), .uart_receive_input(rx)
  );

  always #2.5 pclk = ~pclk;

  // A hung handshake would otherwise stall the run forever.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      summarize();
    end
  end

  function automatic logic [15:0] adr(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    `TB_CHK(e, xe)
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] xd,
                    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `TB_CHK(e, xe)
    if (!xe) `TB_CHK(q, xd)
  endtask

  task automatic pins(input logic [1:0] o, input logic [1:0] oe,
                      input logic [1:0] pu, input logic [1:0] r);
    repeat (2) @(posedge pclk);
    #1;
    `TB_CHK(pin_out, o)
    `TB_CHK(pin_oe, oe)
    `TB_CHK(pullup_on, pu)
    `TB_CHK(rx, r)
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rw_idx[i]) rd(adr(rw_idx[i]), 32'h0, 1'b0);
    pins(2'b00, 2'b00, 2'b00, 2'b00);
    $display("test reset values done");
    foreach (rw_idx[i]) begin
      wr(adr(rw_idx[i]), 32'hffff_ffff, 1'b0);
      rd(adr(rw_idx[i]), 32'h3, 1'b0);
      wr(adr(rw_idx[i]), 32'h0, 1'b0);
    end
    $display("test read back done");
    wr(adr(`GPP_IDX_LEVEL), 32'h3, 1'b1);
    wr(adr(`GPP_IDX_LATCH) | 16'h1, 32'h3, 1'b1);
    rd(adr(`GPP_IDX_LATCH), 32'h0, 1'b0);
    rd(adr(12'h001), 32'h0, 1'b1);
    rd(adr(`GPP_IDX_DIR) | 16'hc000, 32'h0, 1'b1);
    $display("test refusals done");
    pin_in <= 2'b10;
    wr(adr(`GPP_IDX_PULL), 32'h3, 1'b0);
    pins(2'b00, 2'b00, 2'b11, 2'b10);
    rd(adr(`GPP_IDX_LEVEL), 32'h2, 1'b0);
    $display("test input mode done");
    wr(adr(`GPP_IDX_LATCH), 32'h1, 1'b0);
    wr(adr(`GPP_IDX_DIR), 32'h1, 1'b0);
    pin_in <= 2'b11;
    pins(2'b01, 2'b01, 2'b10, 2'b11);
    rd(adr(`GPP_IDX_LEVEL), 32'h2, 1'b0);
    wr(adr(`GPP_IDX_LATCH), 32'h2, 1'b0);
    pins(2'b00, 2'b01, 2'b10, 2'b11);
    $display("test push-pull output done");
    wr(adr(`GPP_IDX_DIR), 32'h3, 1'b0);
    wr(adr(`GPP_IDX_DRIVE), 32'h3, 1'b0);
    pins(2'b00, 2'b01, 2'b11, 2'b11);
    rd(adr(`GPP_IDX_LEVEL), 32'h3, 1'b0);
    $display("test open drain done");
    wr(adr(`GPP_IDX_FSEL), 32'h3, 1'b0);
    tx <= 1'b1;
    pins(2'b00, 2'b00, 2'b11, 2'b11);
    wr(adr(`GPP_IDX_DRIVE), 32'h0, 1'b0);
    pins(2'b11, 2'b11, 2'b00, 2'b11);
    @(posedge pclk);
    tx <= 1'b0;
    pins(2'b00, 2'b11, 2'b00, 2'b11);
    $display("test transmit function done");
    summarize();
  end
endmodule
`default_nettype wire
